// ===== inc/pcstack_regs.vh
`ifndef PCSTACK_REGS_VH
`define PCSTACK_REGS_VH
// ----------------------------------------------------------------
// Register map (byte addresses on APB)
// ----------------------------------------------------------------
`define ADDR_PC_LOW        12'h000
`define ADDR_PC_HIGH_LATCH 12'h004
`define ADDR_PC_UPPER_LATCH 12'h008
`define ADDR_STACK_STATUS  12'h00C
`define ADDR_TOP_LOW       12'h010
`define ADDR_TOP_HIGH      12'h014
`define ADDR_TOP_UPPER     12'h018
`define ADDR_CONFIG        12'h01C
`define ADDR_PC_FULL       12'h020
// ----------------------------------------------------------------
// Fields and reset values
// ----------------------------------------------------------------
`define STAT_FULL_BIT      7
`define STAT_UNDER_BIT     6
`define STACK_STATUS_RST   8'h00
`define CONFIG_RST         8'h01
`define STACK_DEPTH        31
`define PTR_MAX            5'h1F
`define PC_STEP            21'h000002
`define PC_RESET           21'h000000
// ----------------------------------------------------------------
// Core command codes
// ----------------------------------------------------------------
`define CMD_NONE           4'h0
`define CMD_STEP           4'h1
`define CMD_GOTO           4'h2
`define CMD_CALL           4'h3
`define CMD_RETURN         4'h4
`define CMD_INTERRUPT      4'h5
`define CMD_PUSH           4'h6
`define CMD_POP            4'h7
`endif

// ===== hdl/stack_store.v
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------------------------------
// Return address storage, entries 1..DEPTH, entry 0 absent
// ----------------------------------------------------------------
module stack_store #(
    parameter DEPTH = 31,
    parameter AW = 5,
    parameter DW = 21
) (
    // Clock
    input wire clk_sys,
    // Write side
    input wire wr_en,
    input wire [AW-1:0] wr_idx,
    input wire [DW-1:0] wr_data,
    // Read side
    input wire [AW-1:0] rd_idx,
    output wire [DW-1:0] rd_data
);
    reg [DW-1:0] mem_r [1:DEPTH];

    // Index zero has no storage and is only the empty state
    always @(posedge clk_sys) begin
        if (wr_en && wr_idx != {AW{1'b0}}) begin
            mem_r[wr_idx] <= wr_data;
        end
    end

    assign rd_data = (rd_idx == {AW{1'b0}}) ? {DW{1'b0}} : mem_r[rd_idx];
endmodule
`default_nettype wire

// ===== hdl/shadow_reg.v
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------------------------------
// One-level hidden copy of a core register
// ----------------------------------------------------------------
module shadow_reg #(
    parameter W = 8
) (
    // Clock and reset
    input wire clk_sys,
    input wire srst,
    // Capture
    input wire save,
    input wire [W-1:0] live,
    // Copy out
    output reg [W-1:0] copy_r
);
    // Each save overwrites the previous copy
    always @(posedge clk_sys) begin
        if (srst) begin
            copy_r <= {W{1'b0}};
        end else if (save) begin
            copy_r <= live;
        end
    end
endmodule
`default_nettype wire

// ===== hdl/program_counter_return_stack.v
// Behaviour
// (RQ1) 21-bit PC in three byte registers
// (RQ2) Only low byte software accessible; latches update rest (the code also reads the whole PC at ADDR_PC_FULL)
// (RQ3) Low byte write loads high/upper from latches
// (RQ4) Low byte read copies high/upper into latches
// (RQ5) PC bit zero stays zero; steps by two
// (RQ6) Calls, gotos, branches load PC directly
// (RQ7) 31 by 21-bit stack, 5-bit pointer
// (RQ8) Push: increment pointer, then store return address
// (RQ9) Return: load PC from top, then decrement
// (RQ10) Calls and returns leave latches unchanged
// (RQ11) Reset clears pointer; zero is empty
// (RQ12) Top entry registers access selected entry only
// (RQ13) 31 pushes set full flag; software clears
// (RQ14) Error reset on: 31st push stores, resets
// (RQ15) Error reset off: pointer sticks at 31
// (RQ16) Empty pop loads zero, sets underflow flag
// (RQ17) Error reset enable selects flag-only or reset
// (RQ18) Push stores PC; pop only discards top
// (RQ19) Interrupt copies status, working, bank to shadow
// (RQ20) Fast return restores; fast call saves shadows
// (RQ21) Status: full b7, underflow b6, b5 zero, pointer
// (RQ22) Software masks interrupts around top entry access
//
// The placing of the registers and the APB register port were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "pcstack_regs.vh"
module program_counter_return_stack #(
    parameter DEPTH = `STACK_DEPTH
) (
    // Clock and reset
    input wire clk_sys,
    input wire srst,
    input wire por,
    // APB slave
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    // Core command port
    input wire [3:0] cmd,
    input wire cmd_fast,
    input wire [20:0] cmd_target,
    // Core registers for the shadow copies
    input wire [7:0] status_in,
    input wire [7:0] working_register_in,
    input wire [7:0] bank_select_register_in,
    // Program counter and restore outputs
    output reg [20:0] pc_out,
    output reg restore_valid,
    output reg [7:0] status_restore,
    output reg [7:0] working_register_restore,
    output reg [7:0] bank_select_register_restore,
    output reg stack_reset_req
);
    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    reg [20:0] pc_r;
    reg [20:0] pc_nxt;
    reg [7:0] pc_high_latch_r;
    reg [7:0] pc_high_latch_nxt;
    reg [4:0] pc_upper_latch_r;
    reg [4:0] pc_upper_latch_nxt;
    reg [4:0] ptr_r;
    reg [4:0] ptr_nxt;
    reg full_r;
    reg full_nxt;
    reg under_r;
    reg under_nxt;
    reg stack_error_reset_enable_r;
    reg err_reset;
    reg wr_en;
    reg [4:0] wr_idx;
    reg [20:0] wr_data;
    reg shadow_save;
    reg [31:0] rdata_nxt;
    wire [20:0] top_entry;
    wire [7:0] status_copy;
    wire [7:0] working_copy;
    wire [7:0] bank_copy;
    wire apb_setup;
    wire apb_wr;
    wire apb_rd;
    wire is_push;
    wire is_pop;
    wire [20:0] ret_addr;
    wire fast_save;
    wire fast_ret;

    assign apb_setup = psel && !penable;
    // Access completes in the cycle pready is high
    assign apb_wr = psel && penable && pready && pwrite;
    assign apb_rd = psel && penable && pready && !pwrite;
    assign is_push = (cmd == `CMD_CALL) || (cmd == `CMD_INTERRUPT) || (cmd == `CMD_PUSH);
    assign is_pop = (cmd == `CMD_RETURN) || (cmd == `CMD_POP);
    // Return address: the instruction after the current one
    assign ret_addr = pc_r + `PC_STEP;
    // Fast option: a fast call saves like an interrupt, a fast return restores
    assign fast_save = (cmd == `CMD_INTERRUPT) || (cmd == `CMD_CALL && cmd_fast);
    assign fast_ret = (cmd == `CMD_RETURN) && cmd_fast;

    // ----------------------------------------------------------------
    // Sub-blocks
    // ----------------------------------------------------------------
    // Reads are combinational, so the top entry follows the pointer at once
    stack_store #(.DEPTH(DEPTH), .AW(5), .DW(21)) u_store (
        .clk_sys(clk_sys),
        .wr_en(wr_en),
        .wr_idx(wr_idx),
        .wr_data(wr_data),
        .rd_idx(ptr_r),
        .rd_data(top_entry)
    );

    // Three one-level copies share one save strobe
    shadow_reg #(.W(8)) u_shadow_status (
        .clk_sys(clk_sys),
        .srst(srst),
        .save(shadow_save),
        .live(status_in),
        .copy_r(status_copy)
    );

    shadow_reg #(.W(8)) u_shadow_working (
        .clk_sys(clk_sys),
        .srst(srst),
        .save(shadow_save),
        .live(working_register_in),
        .copy_r(working_copy)
    );

    shadow_reg #(.W(8)) u_shadow_bank (
        .clk_sys(clk_sys),
        .srst(srst),
        .save(shadow_save),
        .live(bank_select_register_in),
        .copy_r(bank_copy)
    );

    // ----------------------------------------------------------------
    // Core commands and software accesses, next-state logic
    // ----------------------------------------------------------------
    // Core commands win over a software write in the same cycle,
    // since software is expected to keep interrupts off meanwhile (RQ22)
    always @* begin
        pc_nxt = pc_r;
        pc_high_latch_nxt = pc_high_latch_r;
        pc_upper_latch_nxt = pc_upper_latch_r;
        ptr_nxt = ptr_r;
        full_nxt = full_r;
        under_nxt = under_r;
        err_reset = 1'b0;
        wr_en = 1'b0;
        wr_idx = ptr_r;
        wr_data = ret_addr;
        shadow_save = 1'b0;
        // Software side first; hardware events below override flags
        if (apb_wr) begin
            case (paddr)
                `ADDR_PC_LOW: begin
                    pc_nxt = {pc_upper_latch_r, pc_high_latch_r, pwdata[7:1], 1'b0}; // RQ3 RQ5
                end
                `ADDR_PC_HIGH_LATCH: begin
                    pc_high_latch_nxt = pwdata[7:0]; // RQ2
                end
                `ADDR_PC_UPPER_LATCH: begin
                    pc_upper_latch_nxt = pwdata[4:0]; // RQ2
                end
                `ADDR_STACK_STATUS: begin
                    // Flags clear only; writing one leaves them
                    if (!pwdata[`STAT_FULL_BIT]) full_nxt = 1'b0; // RQ21 RQ13
                    if (!pwdata[`STAT_UNDER_BIT]) under_nxt = 1'b0; // RQ21 RQ16
                    ptr_nxt = pwdata[4:0];
                end
                // At pointer zero the store drops the write, nothing lands
                `ADDR_TOP_LOW: begin
                    wr_en = 1'b1; // RQ12
                    wr_data = {top_entry[20:8], pwdata[7:0]};
                end
                `ADDR_TOP_HIGH: begin
                    wr_en = 1'b1; // RQ12
                    wr_data = {top_entry[20:16], pwdata[7:0], top_entry[7:0]};
                end
                `ADDR_TOP_UPPER: begin
                    wr_en = 1'b1; // RQ12
                    wr_data = {pwdata[4:0], top_entry[15:0]};
                end
                default: begin
                end
            endcase
        end else if (apb_rd && paddr == `ADDR_PC_LOW) begin
            pc_high_latch_nxt = pc_r[15:8]; // RQ4
            pc_upper_latch_nxt = pc_r[20:16]; // RQ4
        end
        // Core commands; latches are never touched here (RQ10)
        case (cmd)
            `CMD_STEP: begin
                pc_nxt = ret_addr; // RQ5
            end
            `CMD_GOTO: begin
                pc_nxt = {cmd_target[20:1], 1'b0}; // RQ6
            end
            `CMD_CALL, `CMD_INTERRUPT, `CMD_PUSH: begin
                shadow_save = fast_save; // RQ19 RQ20
                // PUSH stores the current PC, calls the next one (RQ18)
                wr_data = (cmd == `CMD_PUSH) ? pc_r : ret_addr;
                if (cmd != `CMD_PUSH) begin
                    pc_nxt = {cmd_target[20:1], 1'b0}; // RQ6
                end
                if (ptr_r == `PTR_MAX) begin
                    // Pointer stuck at 31: the last entry is not overwritten
                    full_nxt = 1'b1; // RQ15
                end else begin
                    ptr_nxt = ptr_r + 5'h01; // RQ8
                    wr_idx = ptr_r + 5'h01; // RQ8 RQ7
                    wr_en = 1'b1;
                    if (ptr_r + 5'h01 == `PTR_MAX) begin
                        full_nxt = 1'b1; // RQ13
                        err_reset = stack_error_reset_enable_r; // RQ14 RQ17
                    end
                end
            end
            `CMD_RETURN, `CMD_POP: begin
                if (ptr_r == 5'h00) begin
                    // Pointer stays at zero; the flag records the error, and a reset is requested if error reset is enabled
                    under_nxt = 1'b1; // RQ16
                    if (cmd == `CMD_RETURN) pc_nxt = `PC_RESET; // RQ16
                    err_reset = stack_error_reset_enable_r; // RQ17
                end else begin
                    // Pop only discards; return also loads PC (RQ18)
                    if (cmd == `CMD_RETURN) pc_nxt = top_entry; // RQ9
                    ptr_nxt = ptr_r - 5'h01; // RQ9
                end
            end
            default: begin
            end
        endcase
        // Error reset: pointer to zero, PC to vector, flags kept
        // Limitation: this only requests a device reset; the rest of the
        // core must act on stack_reset_req itself
        if (err_reset && (is_push || is_pop)) begin
            ptr_nxt = 5'h00; // RQ14
            pc_nxt = `PC_RESET;
        end
    end

    // ----------------------------------------------------------------
    // Registers
    // ----------------------------------------------------------------
    // Flags survive device reset; only power-on clears them
    always @(posedge clk_sys) begin
        if (por) begin
            full_r <= 1'b0;
            under_r <= 1'b0;
        end else begin
            full_r <= full_nxt; // RQ13
            under_r <= under_nxt;
        end
    end

    // Any reset turns the error reset back on, its safe default
    // Every reset clears the pointer and PC
    always @(posedge clk_sys) begin
        if (srst || por) begin
            pc_r <= `PC_RESET;
            pc_high_latch_r <= 8'h00;
            pc_upper_latch_r <= 5'h00;
            ptr_r <= 5'h00; // RQ11
            stack_error_reset_enable_r <= 1'b1;
            stack_reset_req <= 1'b0;
        end else begin
            pc_r <= pc_nxt; // RQ1
            pc_high_latch_r <= pc_high_latch_nxt;
            pc_upper_latch_r <= pc_upper_latch_nxt;
            ptr_r <= ptr_nxt;
            stack_reset_req <= err_reset; // RQ17
            if (apb_wr && paddr == `ADDR_CONFIG) begin
                stack_error_reset_enable_r <= pwdata[0];
            end
        end
    end

    // Fast return hands the shadow copies back to the core
    always @(posedge clk_sys) begin
        if (srst) begin
            restore_valid <= 1'b0;
            status_restore <= 8'h00;
            working_register_restore <= 8'h00;
            bank_select_register_restore <= 8'h00;
        end else begin
            restore_valid <= fast_ret; // RQ20
            status_restore <= status_copy;
            working_register_restore <= working_copy;
            bank_select_register_restore <= bank_copy;
        end
    end

    always @(posedge clk_sys) begin
        // Mirror of the next PC, so the core sees a jump one edge after it
        if (srst || por) begin
            pc_out <= `PC_RESET;
        end else begin
            pc_out <= pc_nxt;
        end
    end

    // ----------------------------------------------------------------
    // APB read data and ready, no wait states
    // ----------------------------------------------------------------
    // Decoded from the setup address, so data is ready together with pready
    always @* begin
        rdata_nxt = 32'h00000000;
        case (paddr)
            `ADDR_PC_LOW: rdata_nxt = {24'h000000, pc_r[7:0]}; // RQ2
            `ADDR_PC_HIGH_LATCH: rdata_nxt = {24'h000000, pc_high_latch_r};
            `ADDR_PC_UPPER_LATCH: rdata_nxt = {27'h0000000, pc_upper_latch_r};
            `ADDR_STACK_STATUS: rdata_nxt = {24'h000000, full_r, under_r, 1'b0, ptr_r}; // RQ21
            `ADDR_TOP_LOW: rdata_nxt = {24'h000000, top_entry[7:0]}; // RQ12
            `ADDR_TOP_HIGH: rdata_nxt = {24'h000000, top_entry[15:8]};
            `ADDR_TOP_UPPER: rdata_nxt = {27'h0000000, top_entry[20:16]};
            `ADDR_CONFIG: rdata_nxt = {31'h00000000, stack_error_reset_enable_r};
            `ADDR_PC_FULL: rdata_nxt = {11'h000, pc_r};
            default: rdata_nxt = 32'h00000000;
        endcase
    end

    // Ready follows setup by one cycle; unmapped addresses error
    // A refused access still gets its pready, so the master never hangs
    always @(posedge clk_sys) begin
        if (srst) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h00000000;
        end else begin
            pready <= apb_setup;
            pslverr <= apb_setup && (paddr > `ADDR_PC_FULL || paddr[1:0] != 2'b00);
            prdata <= rdata_nxt;
        end
    end
endmodule
`default_nettype wire

// ===== bench/pcrs_props.sv
`timescale 1ns/1ps
`default_nettype none
`include "pcstack_regs.vh"
module pcrs_props (
    // Clock and resets
    input wire logic clk_sys,
    input wire logic srst,
    input wire logic por,
    // Bus handshake
    input wire logic psel,
    input wire logic penable,
    input wire logic pready,
    // Core side
    input wire logic [3:0] cmd,
    input wire logic cmd_fast,
    input wire logic [20:0] cmd_target,
    input wire logic [7:0] status_in,
    input wire logic [20:0] pc_out,
    input wire logic restore_valid,
    input wire logic [7:0] status_restore,
    input wire logic stack_reset_req
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (srst || por);
    // -------------------------------------------------------------
    // Sequences
    // -------------------------------------------------------------
    sequence s_setup;
        psel && !penable;
    endsequence
    sequence s_isr_then_fast_ret;
        (cmd == `CMD_INTERRUPT || cmd == `CMD_CALL && cmd_fast)
            ##1 !(cmd == `CMD_INTERRUPT || cmd == `CMD_CALL && cmd_fast)
            ##1 (cmd == `CMD_RETURN && cmd_fast);
    endsequence
    // A stack error reset may override the jump, so it is let through
    AST_PC_EVEN: assert property (pc_out[0] == 1'b0) else $error("pc odd");
    AST_STEP: assert property (cmd == `CMD_STEP |=> pc_out == $past(pc_out) + `PC_STEP)
        else $error("step not by two");
    AST_JUMP: assert property ((cmd == `CMD_GOTO || cmd == `CMD_CALL) |=>
        stack_reset_req || pc_out == ($past(cmd_target) & 21'h1FFFFE)) else $error("bad jump");
    AST_READY: assert property (s_setup |=> pready ##1 !pready)
        else $error("bus answer late or long");
    AST_READY_ONLY_ACCESS: assert property (pready |-> psel && penable)
        else $error("answer outside access");
    AST_RESTORE: assert property (cmd == `CMD_RETURN && cmd_fast |=> restore_valid)
        else $error("no restore");
    AST_NO_RESTORE: assert property (!(cmd == `CMD_RETURN && cmd_fast) |=> !restore_valid)
        else $error("spurious restore");
    AST_SHADOW: assert property (s_isr_then_fast_ret |=> status_restore == $past(status_in, 3))
        else $error("shadow mismatch");
    AST_RESET_CAUSE: assert property (stack_reset_req |-> $past(cmd) inside {`CMD_CALL,
        `CMD_INTERRUPT, `CMD_RETURN, `CMD_PUSH, `CMD_POP}) else $error("reset without cause");
    AST_RESET_PULSE: assert property (stack_reset_req |=> !stack_reset_req)
        else $error("reset request too long");
endmodule
bind program_counter_return_stack pcrs_props u_props (.clk_sys(clk_sys), .srst(srst),
    .por(por), .psel(psel), .penable(penable), .pready(pready), .cmd(cmd),
    .cmd_fast(cmd_fast), .cmd_target(cmd_target), .status_in(status_in), .pc_out(pc_out),
    .restore_valid(restore_valid), .status_restore(status_restore),
    .stack_reset_req(stack_reset_req));
`default_nettype wire

// ===== bench/core_model.sv
`timescale 1ns/1ps
`default_nettype none
`include "pcstack_regs.vh"
module core_model (
    // Clock
    input wire logic clk_sys,
    // Command port
    output logic [3:0] cmd,
    output logic cmd_fast,
    output logic [20:0] target,
    // Live core registers
    output logic [7:0] status,
    output logic [7:0] working,
    output logic [7:0] bank
);
    initial begin
        cmd = `CMD_NONE;
        cmd_fast = 1'b0;
        target = 21'h000000;
        {status, working, bank} = 24'h000000;
    end
    // One command per call; live registers flip afterwards so a late capture shows
    task op(input logic [3:0] c, input logic f, input logic [20:0] t, input logic [7:0] s);
        @(posedge clk_sys);
        cmd <= c;
        cmd_fast <= f;
        target <= t;
        status <= s;
        working <= ~s;
        bank <= s + 8'h01;
        @(posedge clk_sys);
        cmd <= `CMD_NONE;
        cmd_fast <= 1'b0;
        {status, working, bank} <= ~{s, ~s, s + 8'h01};
    endtask
endmodule
`default_nettype wire

// ===== bench/tb_program_counter_return_stack.sv
`timescale 1ns/1ps
`default_nettype none
`include "pcstack_regs.vh"
module tb_program_counter_return_stack;
    logic clk_sys = 1'b0;
    logic srst = 1'b1, por = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, err;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h00000000, prdata, rd;
    logic pready, pslverr, cmd_fast, restore_valid, stack_reset_req;
    logic [3:0] cmd;
    logic [20:0] cmd_target, pc_out;
    logic [7:0] st, wr, bk, st_r, wr_r, bk_r;
    int bad_count = 0, samples_checked = 0, rst_seen = 0, rv_seen = 0, i;
    always #2 clk_sys = ~clk_sys;
    core_model core (.clk_sys(clk_sys), .cmd(cmd), .cmd_fast(cmd_fast), .target(cmd_target),
        .status(st), .working(wr), .bank(bk));
    program_counter_return_stack dut (.clk_sys(clk_sys), .srst(srst), .por(por), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .cmd(cmd), .cmd_fast(cmd_fast),
        .cmd_target(cmd_target), .status_in(st), .working_register_in(wr),
        .bank_select_register_in(bk), .pc_out(pc_out), .restore_valid(restore_valid),
        .status_restore(st_r), .working_register_restore(wr_r),
        .bank_select_register_restore(bk_r), .stack_reset_req(stack_reset_req));
    // Pulses are counted so a later compare can see them
    always @(posedge clk_sys) begin
        if (stack_reset_req === 1'b1) rst_seen <= rst_seen + 1;
        if (restore_valid === 1'b1) rv_seen <= rv_seen + 1;
    end
    task stop_test;
        $display("compares %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    task chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            bad_count++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // -------------------------------------------------------------
    // Bus master: request held until pready is sampled high
    // -------------------------------------------------------------
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk_sys);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        do begin
            @(posedge clk_sys);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1) begin
            bad_count++;
            stop_test;
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task rchk(input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h00000000);
        chk(rd, exp);
    endtask
    // -------------------------------------------------------------
    // Main sequence
    // -------------------------------------------------------------
    initial begin
        repeat (16) @(posedge clk_sys);
        srst <= 1'b0;
        por <= 1'b0;
        rchk(`ADDR_STACK_STATUS, 32'h00000000);
        rchk(`ADDR_CONFIG, 32'h00000001);
        apb(1'b0, 12'h024, 32'h00000000);
        chk(err, 32'h00000001);
        apb(1'b1, `ADDR_PC_HIGH_LATCH, 32'h00000012);
        apb(1'b1, `ADDR_PC_UPPER_LATCH, 32'h00000003);
        apb(1'b1, `ADDR_PC_LOW, 32'h00000041);
        rchk(`ADDR_PC_FULL, 32'h00031240);
        core.op(`CMD_GOTO, 1'b0, 21'h0ABCD1, 8'h00);
        rchk(`ADDR_PC_FULL, 32'h000ABCD0);
        rchk(`ADDR_PC_LOW, 32'h000000D0);
        rchk(`ADDR_PC_HIGH_LATCH, 32'h000000BC);
        rchk(`ADDR_PC_UPPER_LATCH, 32'h0000000A);
        core.op(`CMD_STEP, 1'b0, 21'h000000, 8'h00);
        rchk(`ADDR_PC_FULL, 32'h000ABCD2);
        apb(1'b1, `ADDR_PC_HIGH_LATCH, 32'h00000077);
        core.op(`CMD_CALL, 1'b0, 21'h000100, 8'h00);
        rchk(`ADDR_STACK_STATUS, 32'h00000001);
        rchk(`ADDR_TOP_LOW, 32'h000000D4);
        rchk(`ADDR_TOP_HIGH, 32'h000000BC);
        rchk(`ADDR_TOP_UPPER, 32'h0000000A);
        rchk(`ADDR_PC_HIGH_LATCH, 32'h00000077);
        // Interrupts stay off while the top entry is rewritten
        apb(1'b1, `ADDR_TOP_LOW, 32'h00000020);
        core.op(`CMD_RETURN, 1'b0, 21'h000000, 8'h00);
        rchk(`ADDR_PC_FULL, 32'h000ABC20);
        rchk(`ADDR_STACK_STATUS, 32'h00000000);
        apb(1'b1, `ADDR_CONFIG, 32'h00000000);
        core.op(`CMD_RETURN, 1'b0, 21'h000000, 8'h00);
        rchk(`ADDR_PC_FULL, 32'h00000000);
        rchk(`ADDR_STACK_STATUS, 32'h00000040);
        chk(rst_seen, 32'h00000000);
        apb(1'b1, `ADDR_STACK_STATUS, 32'h00000000);
        rchk(`ADDR_STACK_STATUS, 32'h00000000);
        core.op(`CMD_GOTO, 1'b0, 21'h000200, 8'h00);
        core.op(`CMD_PUSH, 1'b0, 21'h000000, 8'h00);
        rchk(`ADDR_TOP_HIGH, 32'h00000002);
        core.op(`CMD_POP, 1'b0, 21'h000000, 8'h00);
        rchk(`ADDR_STACK_STATUS, 32'h00000000);
        rchk(`ADDR_PC_FULL, 32'h00000200);
        // Fill to the brim, each entry tagged by its own address
        for (i = 1; i <= 31; i++) begin
            core.op(`CMD_GOTO, 1'b0, 21'(i * 4), 8'h00);
            core.op(`CMD_PUSH, 1'b0, 21'h000000, 8'h00);
        end
        rchk(`ADDR_STACK_STATUS, 32'h0000009F);
        core.op(`CMD_GOTO, 1'b0, 21'h000080, 8'h00);
        core.op(`CMD_PUSH, 1'b0, 21'h000000, 8'h00);
        rchk(`ADDR_STACK_STATUS, 32'h0000009F);
        rchk(`ADDR_TOP_LOW, 32'h0000007C);
        apb(1'b1, `ADDR_STACK_STATUS, 32'h0000001E);
        rchk(`ADDR_STACK_STATUS, 32'h0000001E);
        apb(1'b1, `ADDR_CONFIG, 32'h00000001);
        core.op(`CMD_PUSH, 1'b0, 21'h000000, 8'h00);
        repeat (3) @(posedge clk_sys);
        chk(rst_seen, 32'h00000001);
        rchk(`ADDR_STACK_STATUS, 32'h00000080);
        apb(1'b1, `ADDR_STACK_STATUS, 32'h00000000);
        core.op(`CMD_RETURN, 1'b0, 21'h000000, 8'h00);
        repeat (3) @(posedge clk_sys);
        chk(rst_seen, 32'h00000002);
        rchk(`ADDR_STACK_STATUS, 32'h00000040);
        // Device reset keeps the flags; only power-on clears them
        apb(1'b1, `ADDR_STACK_STATUS, 32'h00000045);
        srst <= 1'b1;
        @(posedge clk_sys);
        srst <= 1'b0;
        rchk(`ADDR_STACK_STATUS, 32'h00000040);
        por <= 1'b1;
        @(posedge clk_sys);
        por <= 1'b0;
        rchk(`ADDR_STACK_STATUS, 32'h00000000);
        core.op(`CMD_INTERRUPT, 1'b0, 21'h000008, 8'hA5);
        core.op(`CMD_RETURN, 1'b1, 21'h000000, 8'h00);
        repeat (3) @(posedge clk_sys);
        chk(rv_seen, 32'h00000001);
        chk({st_r, wr_r, bk_r}, 32'h00A55AA6);
        core.op(`CMD_CALL, 1'b1, 21'h000300, 8'h3C);
        core.op(`CMD_RETURN, 1'b1, 21'h000000, 8'h00);
        repeat (3) @(posedge clk_sys);
        chk({st_r, wr_r, bk_r}, 32'h003CC33D);
        stop_test;
    end
endmodule
`default_nettype wire
